/* cstx_port.v */
// Purpose: One transmit port: calibration control copy, sequencer, status
// Assumes: Calibration bits leave at one bit per link clock rising edge
// Notes:   Link clock is sampled, not used as a clock
`timescale 1ns/1ps
`include "cstx_map.vh"

module cstx_port (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       wr_en,
  input  wire [7:0] wr_data,
  input  wire       link_edge,
  input  wire       link_idle,
  input  wire       frame_end,
  input  wire [3:0] rx_enabled,
  input  wire [3:0] rx_valid,
  input  wire       sync_enable,
  input  wire       sync_ok,
  input  wire       async_mode,
  input  wire       tx_error,
  output reg  [7:0] ctrl_reg,
  output reg  [7:0] status_reg,
  output reg        cal_active_reg,
  output reg        cal_bit_reg
);

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  localparam ST_IDLE    = 2'd0;
  localparam ST_PENDING = 2'd1;
  localparam ST_SEND    = 2'd2;

  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [15:0] count_reg;
  reg         is_single_reg;
  reg         per_pend_reg;
  reg  [15:0] cal_len;
  wire        pass_any;
  wire        pass_all;
  wire        pass_now;
  wire        seq_done;
  wire        wr_single;

  always @* begin
    case (ctrl_reg[`CSTX_CAL_LEN_HI:`CSTX_CAL_LEN_LO])
      2'd0:    cal_len = `CSTX_LEN_CODE0;
      2'd1:    cal_len = `CSTX_LEN_CODE1;
      2'd2:    cal_len = `CSTX_LEN_CODE2;
      default: cal_len = `CSTX_LEN_CODE3;
    endcase
  end

  assign seq_done  = (state_reg == ST_SEND) && link_edge && (count_reg == cal_len);
  assign wr_single = wr_en && wr_data[`CSTX_CAL_SINGLE];

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (ctrl_reg[`CSTX_CAL_SINGLE] || per_pend_reg) begin
          state_next = ST_PENDING;
        end
      end
      ST_PENDING: begin
        if (link_idle && link_edge) begin
          state_next = ST_SEND;
        end
      end
      ST_SEND: begin
        if (seq_done) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg      <= ST_IDLE;
      count_reg      <= 16'h0000;
      is_single_reg  <= 1'b0;
      per_pend_reg   <= 1'b0;
      cal_active_reg <= 1'b0;
      cal_bit_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (frame_end && ctrl_reg[`CSTX_CAL_PERIODIC]) begin
        per_pend_reg <= 1'b1;
      end else if (state_reg == ST_PENDING && state_next == ST_SEND && !is_single_reg) begin
        per_pend_reg <= 1'b0;
      end
      if (state_reg == ST_IDLE && state_next == ST_PENDING) begin
        is_single_reg <= ctrl_reg[`CSTX_CAL_SINGLE];
      end
      if (state_next == ST_SEND && state_reg != ST_SEND) begin
        count_reg      <= 16'h0000;
        cal_active_reg <= 1'b1;
        cal_bit_reg    <= ctrl_reg[`CSTX_CAL_INV];
      end else if (state_reg == ST_SEND && link_edge) begin
        count_reg   <= count_reg + 16'h0001;
        cal_bit_reg <= ~cal_bit_reg;
        if (seq_done) begin
          cal_active_reg <= 1'b0;
          cal_bit_reg    <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Control copy and status
  // ------------------------------------------------------------
  assign pass_any = |(rx_enabled & rx_valid);
  assign pass_all = (rx_enabled != 4'h0) && ((rx_enabled & rx_valid) == rx_enabled);
  assign pass_now = ctrl_reg[`CSTX_CAL_PASS_MODE] ? pass_all : pass_any;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg   <= `CSTX_RST_CAL_CTRL;
      status_reg <= `CSTX_RST_STATUS;
    end else begin
      if (wr_en) begin
        ctrl_reg <= wr_data & `CSTX_CAL_MASK;
      end
      // A new write of 1 wins over the hardware clear
      if (seq_done && is_single_reg && !wr_single) begin
        ctrl_reg[`CSTX_CAL_SINGLE] <= 1'b0;
      end
      status_reg[`CSTX_STS_SYNC] <= sync_enable & sync_ok;
      if (async_mode) begin
        status_reg[`CSTX_STS_PASS] <= pass_now & ~tx_error;
      end else begin
        status_reg[`CSTX_STS_PASS] <= pass_now;
      end
    end
  end

endmodule

/* cstx_map.vh */
// Purpose: Offsets, fields, reset values and counts for the transmit skew-calibration block
// Assumes: Byte-wide registers reached over I2C at printed offsets
// Notes:   Included by both design files
`ifndef CSTX_MAP_VH
`define CSTX_MAP_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define CSTX_OFS_PORT_SEL     8'h32
`define CSTX_OFS_CAL_CTRL     8'h34
`define CSTX_OFS_STATUS       8'h35

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CSTX_SEL_RD_PORT      4
`define CSTX_SEL_WR_PORT1     1
`define CSTX_SEL_WR_PORT0     0
`define CSTX_CAL_LEN_HI       5
`define CSTX_CAL_LEN_LO       4
`define CSTX_CAL_PASS_MODE    3
`define CSTX_CAL_INV          2
`define CSTX_CAL_SINGLE       1
`define CSTX_CAL_PERIODIC     0
`define CSTX_STS_PORT_NUM     4
`define CSTX_STS_SYNC         1
`define CSTX_STS_PASS         0

// ------------------------------------------------------------
// Writable masks and reset values
// ------------------------------------------------------------
`define CSTX_SEL_MASK         8'h13
`define CSTX_CAL_MASK         8'h3f
`define CSTX_RST_PORT_SEL     8'h00
`define CSTX_RST_CAL_CTRL     8'h00
`define CSTX_RST_STATUS       8'h00

// ------------------------------------------------------------
// Calibration lengths in bits, minus one
// ------------------------------------------------------------
`define CSTX_LEN_CODE0        16'h03ff
`define CSTX_LEN_CODE1        16'h0fff
`define CSTX_LEN_CODE2        16'h3fff
`define CSTX_LEN_CODE3        16'h7fff

`endif

/* cstx_top.v */
// Purpose: Two transmit ports of skew-calibration control and status behind I2C registers
// Assumes: Byte register port already decoded from I2C; link clock sampled by clk
// Notes:   Unmapped offsets read zero and ignore writes
//
// Behaviour
// - Length code picks 2^10/12/14/15 bits
// - Pass mode: any or all enabled ports
// - Pattern 0101, inverted to 1010 on bit
// - One-shot sends one sequence at idle
// - One-shot uses the periodic length
// - One-shot bit self-clears after sending
// - Periodic sequence after each frame end
// - Status shows selected read port
// - Sync flag shows streams synchronized
// - Sync flag zero when sync disabled
// - Async: pass means actively delivering video
// - Async: errors clear pass
// - Sync mode: pass means data available
// - Per-port copies routed by port select
// - Calibration control resets to zero
// - Read select bit picks readback port
// - Per-port write enables, either or both
`timescale 1ns/1ps
`include "cstx_map.vh"

module cstx_top (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire       link_clk,
  input  wire [1:0] link_idle,
  input  wire [1:0] frame_end,
  input  wire [3:0] rx_enabled,
  input  wire [3:0] rx_valid,
  input  wire       sync_enable,
  input  wire [1:0] sync_ok,
  input  wire       async_mode,
  input  wire [1:0] tx_error,
  output reg  [1:0] cal_active,
  output reg  [1:0] cal_bit
);

  // ------------------------------------------------------------
  // Link clock sampling
  // ------------------------------------------------------------
  // Two stages before edge detect, since link clock is asynchronous
  reg        lclk_s1_reg;
  reg        lclk_s2_reg;
  reg        lclk_s3_reg;
  wire       link_edge;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lclk_s1_reg <= 1'b0;
      lclk_s2_reg <= 1'b0;
      lclk_s3_reg <= 1'b0;
    end else begin
      lclk_s1_reg <= link_clk;
      lclk_s2_reg <= lclk_s1_reg;
      lclk_s3_reg <= lclk_s2_reg;
    end
  end

  assign link_edge = lclk_s2_reg & ~lclk_s3_reg;

  // ------------------------------------------------------------
  // Port select and write routing
  // ------------------------------------------------------------
  reg  [7:0] sel_reg;
  wire       wr_ctrl;
  wire [1:0] port_wr;
  wire [7:0] ctrl0;
  wire [7:0] ctrl1;
  wire [7:0] sts0;
  wire [7:0] sts1;
  wire [1:0] act;
  wire [1:0] bitv;
  wire [7:0] sts_sel;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_reg <= `CSTX_RST_PORT_SEL;
    end else if (reg_wr && reg_addr == `CSTX_OFS_PORT_SEL) begin
      sel_reg <= reg_wdata & `CSTX_SEL_MASK;
    end
  end

  assign wr_ctrl = reg_wr && (reg_addr == `CSTX_OFS_CAL_CTRL);
  assign port_wr[0] = wr_ctrl & sel_reg[`CSTX_SEL_WR_PORT0];
  assign port_wr[1] = wr_ctrl & sel_reg[`CSTX_SEL_WR_PORT1];

  cstx_port u_port0 (
    .clk            (clk),
    .rst_b          (rst_b),
    .wr_en          (port_wr[0]),
    .wr_data        (reg_wdata),
    .link_edge      (link_edge),
    .link_idle      (link_idle[0]),
    .frame_end      (frame_end[0]),
    .rx_enabled     (rx_enabled),
    .rx_valid       (rx_valid),
    .sync_enable    (sync_enable),
    .sync_ok        (sync_ok[0]),
    .async_mode     (async_mode),
    .tx_error       (tx_error[0]),
    .ctrl_reg       (ctrl0),
    .status_reg     (sts0),
    .cal_active_reg (act[0]),
    .cal_bit_reg    (bitv[0])
  );

  cstx_port u_port1 (
    .clk            (clk),
    .rst_b          (rst_b),
    .wr_en          (port_wr[1]),
    .wr_data        (reg_wdata),
    .link_edge      (link_edge),
    .link_idle      (link_idle[1]),
    .frame_end      (frame_end[1]),
    .rx_enabled     (rx_enabled),
    .rx_valid       (rx_valid),
    .sync_enable    (sync_enable),
    .sync_ok        (sync_ok[1]),
    .async_mode     (async_mode),
    .tx_error       (tx_error[1]),
    .ctrl_reg       (ctrl1),
    .status_reg     (sts1),
    .cal_active_reg (act[1]),
    .cal_bit_reg    (bitv[1])
  );

  // ------------------------------------------------------------
  // Readback
  // ------------------------------------------------------------
  assign sts_sel = sel_reg[`CSTX_SEL_RD_PORT] ? sts1 : sts0;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata  <= 8'h00;
      cal_active <= 2'b00;
      cal_bit    <= 2'b00;
    end else begin
      cal_active <= act;
      cal_bit    <= bitv;
      if (reg_rd) begin
        case (reg_addr)
          `CSTX_OFS_PORT_SEL: reg_rdata <= sel_reg;
          `CSTX_OFS_CAL_CTRL: reg_rdata <= sel_reg[`CSTX_SEL_RD_PORT] ? ctrl1 : ctrl0;
          `CSTX_OFS_STATUS: begin
            reg_rdata <= {3'b000, sel_reg[`CSTX_SEL_RD_PORT], 2'b00,
                          sts_sel[`CSTX_STS_SYNC], sts_sel[`CSTX_STS_PASS]};
          end
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule

/* cstx_top_assertions.sv */
// Purpose: Port checks for the skew-calibration block
// Assumes: Link clock of eight clk cycles per period
// Notes:   Port 0 sequence length counted in bits, exact sizes only
`timescale 1ns/1ps
module cstx_top_chk (
  input wire       clk,
  input wire       rst_b,
  input wire       reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_rdata,
  input wire       sync_enable,
  input wire [1:0] cal_active,
  input wire [1:0] cal_bit
);
  // ------------------------------
  // Toggle count of port 0 bits
  // ------------------------------
  reg [15:0] tog_reg;
  reg        act_prev_reg;
  reg        bit_prev_reg;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tog_reg      <= 16'h0000;
      act_prev_reg <= 1'b0;
      bit_prev_reg <= 1'b0;
    end else begin
      act_prev_reg <= cal_active[0];
      bit_prev_reg <= cal_bit[0];
      if (!cal_active[0])
        tog_reg <= 16'h0000;
      else if (!act_prev_reg)
        tog_reg <= 16'h0001;
      else if (cal_bit[0] != bit_prev_reg)
        tog_reg <= tog_reg + 16'h0001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (reg_rd && !(reg_addr inside {8'h32, 8'h34, 8'h35})
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  sel_reserved_a: assert property (reg_rd && reg_addr == 8'h32 |=> (reg_rdata & 8'hec) == 8'h00)
    else $error("select reserved bits set");
  ctrl_reserved_a: assert property (reg_rd && reg_addr == 8'h34 |=> reg_rdata[7:6] == 2'h0)
    else $error("control reserved bits set");
  status_reserved_a: assert property (reg_rd && reg_addr == 8'h35 |=> (reg_rdata & 8'hec) == 8'h00)
    else $error("status reserved bits set");
  sync_off_a: assert property (reg_rd && reg_addr == 8'h35 && !sync_enable && !$past(sync_enable)
    |=> !reg_rdata[1]) else $error("sync flag set while disabled");
  bit_idle_a: assert property (!cal_active[0] |-> !cal_bit[0])
    else $error("calibration bit high while idle");
  bit_steady_a: assert property (cal_active[0] && $past(cal_active[0]) && $changed(cal_bit[0])
    |=> $stable(cal_bit[0])[*4]) else $error("calibration bit faster than link");
  seq_length_a: assert property ($fell(cal_active[0])
    |-> tog_reg inside {16'd1024, 16'd4096, 16'd16384, 16'd32768})
    else $error("calibration length not a legal size");
endmodule
bind cstx_top cstx_top_chk u_chk (.clk(clk), .rst_b(rst_b), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_rdata(reg_rdata), .sync_enable(sync_enable), .cal_active(cal_active), .cal_bit(cal_bit));

/* cstx_rx_model.sv */
// Purpose: Receiver side: counts one port's calibration bits
// Assumes: Bits are seen as level changes on clk
// Notes:   Holds the last sequence until the next starts
`timescale 1ns/1ps
module cstx_rx_model (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        cal_active,
  input  wire        cal_bit,
  output reg         first_bit,
  output reg  [15:0] bit_count
);
  reg act_prev;
  reg bit_prev;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      act_prev  <= 1'b0;
      bit_prev  <= 1'b0;
      first_bit <= 1'b0;
      bit_count <= 16'h0000;
    end else begin
      act_prev <= cal_active;
      bit_prev <= cal_bit;
      if (cal_active && !act_prev) begin
        first_bit <= cal_bit;
        bit_count <= 16'h0001;
      end else if (cal_active && cal_bit != bit_prev)
        bit_count <= bit_count + 16'h0001;
    end
  end
endmodule

/* tb_cstx_top.sv */
// Purpose: Register and calibration tests of the two-port block
// Assumes: Inputs other than link_clk change at the falling clk edge
// Notes:   Only the shortest length is sent, to keep runs short
`timescale 1ns/1ps
module tb_cstx_top;
  reg         clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, link_clk = 1'b0;
  reg  [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00;
  reg  [1:0]  link_idle = 2'h0, frame_end = 2'h0, sync_ok = 2'h0, tx_error = 2'h0;
  reg  [3:0]  rx_enabled = 4'h0, rx_valid = 4'h0;
  reg         sync_enable = 1'b0, async_mode = 1'b0;
  wire [7:0]  reg_rdata;
  wire [1:0]  cal_active, cal_bit;
  wire        rx_first;
  wire [15:0] rx_count;
  wire        rx1_first;
  wire [15:0] rx1_count;
  integer     errors = 0, samples_checked = 0, i, n;
  always #25 clk = ~clk;
  initial #7 forever #200 link_clk = ~link_clk;
  cstx_top dut (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .link_clk(link_clk), .link_idle(link_idle),
    .frame_end(frame_end), .rx_enabled(rx_enabled), .rx_valid(rx_valid),
    .sync_enable(sync_enable), .sync_ok(sync_ok), .async_mode(async_mode),
    .tx_error(tx_error), .cal_active(cal_active), .cal_bit(cal_bit));
  cstx_rx_model u_rx (.clk(clk), .rst_b(rst_b), .cal_active(cal_active[0]),
    .cal_bit(cal_bit[0]), .first_bit(rx_first), .bit_count(rx_count));
  cstx_rx_model u_rx1 (.clk(clk), .rst_b(rst_b), .cal_active(cal_active[1]),
    .cal_bit(cal_bit[1]), .first_bit(rx1_first), .bit_count(rx1_count));
  // ------------------------------
  // Access and check tasks
  // ------------------------------
  task results;
    begin
      if (errors == 0 && samples_checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task chk(input string name, input [15:0] exp, input logic [15:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        $display("Error %s expected %h seen %h", name, exp, got);
        errors = errors + 1;
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk); reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
      @(negedge clk); reg_wr = 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    begin
      @(negedge clk); reg_rd = 1'b1; reg_addr = a;
      @(negedge clk); reg_rd = 1'b0;
      chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
    end
  endtask
  // Bounded wait; a stuck sequencer must not hang the run
  task wait_act(input v);
    begin
      n = 0;
      while (cal_active[0] !== v && n < 12000) begin
        @(negedge clk); n = n + 1;
      end
      if (cal_active[0] !== v) begin
        chk("cal_active", {15'h0000, v}, {15'h0000, cal_active[0]});
        results;
      end
    end
  endtask
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    rd(8'h32, 8'h00); rd(8'h34, 8'h00); rd(8'h35, 8'h00);
    rd(8'h33, 8'h00);
    wr(8'h32, 8'hff); rd(8'h32, 8'h13);
    wr(8'h34, 8'hfc); rd(8'h34, 8'h3c);
    wr(8'h35, 8'h13); wr(8'h32, 8'h00); rd(8'h34, 8'h3c);
    wr(8'h34, 8'h01); rd(8'h34, 8'h3c);
    wr(8'h32, 8'h01); wr(8'h34, 8'h08); wr(8'h32, 8'h12); wr(8'h34, 8'h30);
    rd(8'h34, 8'h30); rd(8'h35, 8'h10);
    wr(8'h32, 8'h00); rd(8'h34, 8'h08); rd(8'h35, 8'h00);
    wr(8'h32, 8'h03);
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h34, {2'h0, i[1:0], 4'h0}); rd(8'h34, {2'h0, i[1:0], 4'h0});
    end
    wr(8'h34, 8'h00); rx_enabled = 4'h3; rx_valid = 4'h1; rd(8'h35, 8'h01);
    wr(8'h34, 8'h08); rd(8'h35, 8'h00);
    rx_valid = 4'h3; rd(8'h35, 8'h01);
    tx_error = 2'h1; rd(8'h35, 8'h01);
    async_mode = 1'b1; rd(8'h35, 8'h00);
    tx_error = 2'h0; rd(8'h35, 8'h01);
    sync_ok = 2'h1; rd(8'h35, 8'h01);
    sync_enable = 1'b1; rd(8'h35, 8'h03);
    sync_ok = 2'h0; rd(8'h35, 8'h01);
    // One-shot held back until the link goes idle
    wr(8'h32, 8'h03); wr(8'h34, 8'h06);
    repeat (200) @(negedge clk);
    chk("cal_active", 16'h0000, {14'h0000, cal_active});
    link_idle = 2'h3;
    wait_act(1'b1);
    wait_act(1'b0);
    chk("first_bit", 16'h0001, {15'h0000, rx_first});
    chk("bit_count", 16'd1024, rx_count);
    chk("port1_first_bit", 16'h0001, {15'h0000, rx1_first});
    chk("port1_bit_count", 16'd1024, rx1_count);
    rd(8'h34, 8'h04);
    wr(8'h32, 8'h13); rd(8'h34, 8'h04);
    repeat (200) @(negedge clk);
    chk("cal_active", 16'h0000, {14'h0000, cal_active});
    wr(8'h34, 8'h01); frame_end = 2'h1;
    @(negedge clk); frame_end = 2'h0;
    wait_act(1'b1);
    chk("cal_active", 16'h0001, {14'h0000, cal_active});
    wait_act(1'b0);
    chk("first_bit", 16'h0000, {15'h0000, rx_first});
    chk("bit_count", 16'd1024, rx_count);
    wr(8'h34, 8'h00); frame_end = 2'h1;
    @(negedge clk); frame_end = 2'h0;
    repeat (200) @(negedge clk);
    chk("cal_active", 16'h0000, {14'h0000, cal_active});
    // Reset in mid-run must bring the select and control registers back to zero
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    rd(8'h32, 8'h00); rd(8'h34, 8'h00);
    results;
  end
endmodule
